// ---- design/dcf_fifo_top.sv ----
/*
 * FIFO with standard and fall-through timing, status flags,
 * programmable offsets and an AHB-Lite register slave.
 * Assumes write and read logic run on clk; master reset is a
 * synchronous pin and must stay low at least three cycles.
 */
// Implementation choices: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module dcf_fifo_top (
    // System
    input wire logic clk,
    input wire logic rstn,
    // Master reset and straps
    input wire logic masterResetN,
    input wire logic modeSelectSerialIn,
    input wire logic flagTimingSelect,
    input wire logic offsetLoadSelect,
    input wire logic defaultOffsetSelectA,
    input wire logic defaultOffsetSelectB,
    input wire logic inWidth18,
    input wire logic outWidth18,
    // Write port
    input wire logic writeEnN,
    input wire logic [dcf_pkg::DATA_W-1:0] writeData,
    // Read port
    input wire logic readEnN,
    output logic [dcf_pkg::DATA_W-1:0] readDataOut,
    // Status flags, active low
    output logic emptyFlagN,
    output logic fullFlagN,
    output logic almostEmptyFlagN,
    output logic almostFullFlagN,
    output logic halfFullFlagN,
    output logic outputReadyN,
    output logic inputSpaceN,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata
);
    import dcf_pkg::*;

    // Latched configuration
    logic fwftMode, syncFlags, in18, out18, loadSel;
    logic [CNT_W-1:0] emptyOfs, fullOfs;
    // Pointers, binary and gray, local and synchronised
    logic [CNT_W-1:0] wPtr, rPtr, wGray, rGray, wGraySync, rGraySync;
    logic [CNT_W-1:0] wPtrSync, rPtrSync, next_wPtr, next_rPtr;
    // Counts and decisions
    logic master_reset_n, wrFull, rdEmpty, wrAccept, rdFetch;
    logic [CNT_W-1:0] depth, wrCount, rdCount, exCount, aeCount;
    logic [CNT_W-1:0] afCount, afLevel, hfLevel, ofsDefault;
    logic [DATA_W-1:0] wrWord;
    logic [2:0] ofsSel;
    // Bus side
    logic ahbSel, apWrite, wrEmptyOfs, wrFullOfs;
    logic [11:0] apAddr;
    logic [CNT_W-1:0] emptyOfsView, fullOfsView;
    logic [31:0] statusWord, configWord, next_hrdata;

    assign master_reset_n = !masterResetN;

    // Straps are caught by the clock while master reset is low
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fwftMode <= 1'b0;
            syncFlags <= 1'b0;
            in18 <= 1'b0;
            out18 <= 1'b0;
            loadSel <= 1'b0;
        end else if (master_reset_n) begin
            fwftMode <= modeSelectSerialIn;
            syncFlags <= flagTimingSelect;
            in18 <= inWidth18;
            out18 <= outWidth18;
            loadSel <= offsetLoadSelect;
        end
    end

    // Depth and thresholds follow the latched widths
    assign depth = (in18 || out18) ? DEPTH_X18 : DEPTH_X9;
    assign hfLevel = (depth >> 1) + CNT_W'(1);
    assign afLevel = depth - fullOfs;
    assign ofsSel = {offsetLoadSelect, defaultOffsetSelectA,
                     defaultOffsetSelectB};
    assign ofsDefault = CNT_W'(OFS_DEF[ofsSel]);

    // Narrow input keeps only the low lane
    assign wrWord = in18 ? writeData
                         : {{(DATA_W-NARROW_W){1'b0}},
                            writeData[NARROW_W-1:0]};

    // Write side sees the read pointer through the synchroniser
    assign wrCount = wPtr - rPtrSync;
    assign wrFull = (wrCount >= depth);
    assign wrAccept = !writeEnN && !wrFull && !master_reset_n;
    assign next_wPtr = wPtr + CNT_W'(1);

    // Read side sees the write pointer through the synchroniser
    assign rdCount = wPtrSync - rPtr;
    assign rdEmpty = (rdCount == '0);
    // Fall-through refills the output word on its own
    assign rdFetch = !master_reset_n && !rdEmpty &&
                     (fwftMode ? (outputReadyN || !readEnN)
                               : !readEnN);
    assign next_rPtr = rPtr + CNT_W'(1);

    // Exact count mixes both sides; safe because clk is shared
    assign exCount = wPtr - rPtr;
    assign aeCount = syncFlags ? rdCount : exCount;
    assign afCount = syncFlags ? wrCount : exCount;

    // Write pointer, binary and gray kept in step
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wPtr <= '0;
            wGray <= '0;
        end else if (master_reset_n) begin
            wPtr <= '0;
            wGray <= '0;
        end else if (wrAccept) begin
            wPtr <= next_wPtr;
            wGray <= next_wPtr ^ (next_wPtr >> 1);
        end
    end

    // Read pointer; only a fetch moves it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rPtr <= '0;
            rGray <= '0;
        end else if (master_reset_n) begin
            rPtr <= '0;
            rGray <= '0;
        end else if (rdFetch) begin
            rPtr <= next_rPtr;
            rGray <= next_rPtr ^ (next_rPtr >> 1);
        end
    end

    // Crossings; two stages each way
    dcf_gray_sync u_wsync (
        .clk(clk),
        .rstn(rstn),
        .clr(master_reset_n),
        .grayIn(wGray),
        .grayOut(wGraySync)
    );
    dcf_gray_sync u_rsync (
        .clk(clk),
        .rstn(rstn),
        .clr(master_reset_n),
        .grayIn(rGray),
        .grayOut(rGraySync)
    );

    // Gray back to binary, one xor-reduction per bit
    genvar gi;
    generate
        for (gi = 0; gi < CNT_W; gi++) begin : g_gray2bin
            assign wPtrSync[gi] = ^wGraySync[CNT_W-1:gi];
            assign rPtrSync[gi] = ^rGraySync[CNT_W-1:gi];
        end
    endgenerate

    // Storage; its read register is the data output
    dcf_ram u_ram (
        .clk(clk),
        .rstn(rstn),
        .wrEn(wrAccept),
        .wrAddr(wPtr[ADDR_W-1:0]),
        .wrData(wrWord),
        .rdEn(rdFetch),
        .rdAddr(rPtr[ADDR_W-1:0]),
        .rdData(readDataOut)
    );

    // Flags recomputed every cycle, so they fall back on reads too
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            emptyFlagN <= 1'b0;
            fullFlagN <= 1'b1;
            almostEmptyFlagN <= 1'b0;
            almostFullFlagN <= 1'b1;
            halfFullFlagN <= 1'b1;
            inputSpaceN <= 1'b1;
        end else begin
            emptyFlagN <= fwftMode || !rdEmpty;
            fullFlagN <= fwftMode || !wrFull;
            inputSpaceN <= !fwftMode || wrFull;
            almostEmptyFlagN <= (aeCount > emptyOfs);
            almostFullFlagN <= (afCount < afLevel);
            halfFullFlagN <= (exCount < hfLevel);
        end
    end

    // Output ready marks a held word in fall-through timing only
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            outputReadyN <= 1'b1;
        end else if (master_reset_n || !fwftMode) begin
            outputReadyN <= 1'b1;
        end else if (rdFetch) begin
            outputReadyN <= 1'b0;
        end else if (!readEnN) begin
            outputReadyN <= 1'b1;
        end
    end

    // Offsets: defaults at master reset, else software may rewrite
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            emptyOfs <= CNT_W'(OFS_DEF[OFS_RESET_IDX]);
            fullOfs <= CNT_W'(OFS_DEF[OFS_RESET_IDX]);
        end else if (master_reset_n) begin
            emptyOfs <= ofsDefault;
            fullOfs <= ofsDefault;
        end else begin
            if (wrEmptyOfs) begin
                emptyOfs <= hwdata[CNT_W-1:0];
            end
            if (wrFullOfs) begin
                fullOfs <= hwdata[CNT_W-1:0];
            end
        end
    end

    // Bus address phase decode
    assign ahbSel = hsel && htrans[HTRANS_ACTIVE] && hready;
    assign wrEmptyOfs = apWrite && (apAddr == REG_EMPTY_OFS);
    assign wrFullOfs = apWrite && (apAddr == REG_FULL_OFS);
    // Bypass so a read right after a write sees the new value
    assign emptyOfsView = wrEmptyOfs ? hwdata[CNT_W-1:0] : emptyOfs;
    assign fullOfsView = wrFullOfs ? hwdata[CNT_W-1:0] : fullOfs;

    // Status and configuration words
    always_comb begin
        statusWord = '0;
        statusWord[STAT_EMPTY] = emptyFlagN;
        statusWord[STAT_FULL] = fullFlagN;
        statusWord[STAT_AEMPTY] = almostEmptyFlagN;
        statusWord[STAT_AFULL] = almostFullFlagN;
        statusWord[STAT_HALF] = halfFullFlagN;
        statusWord[STAT_OREADY] = outputReadyN;
        statusWord[STAT_ISPACE] = inputSpaceN;
        statusWord[STAT_COUNT +: CNT_W] = exCount;
        configWord = '0;
        configWord[CFG_FALL_THROUGH_TIMING] = fwftMode;
        configWord[CFG_SYNCFLAG] = syncFlags;
        configWord[CFG_IN18] = in18;
        configWord[CFG_OUT18] = out18;
        configWord[CFG_LOAD] = loadSel;
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        next_hrdata = '0;
        if (!ahbSel || hwrite) begin
            next_hrdata = '0;
        end else if (haddr[11:0] == REG_EMPTY_OFS) begin
            next_hrdata = 32'(emptyOfsView);
        end else if (haddr[11:0] == REG_FULL_OFS) begin
            next_hrdata = 32'(fullOfsView);
        end else if (haddr[11:0] == REG_STATUS) begin
            next_hrdata = statusWord;
        end else if (haddr[11:0] == REG_CONFIG) begin
            next_hrdata = configWord;
        end
    end

    // Zero-wait slave: read data fetched at the address phase
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            apWrite <= 1'b0;
            apAddr <= '0;
            hrdata <= '0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            apWrite <= ahbSel && hwrite;
            apAddr <= haddr[11:0];
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Checks on the flag and pointer logic
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_first_word;
        fwftMode && masterResetN && outputReadyN &&
        (exCount == '0) && wrAccept;
    endsequence

    sequence s_full_read;
        !fwftMode && masterResetN && wrFull && rdFetch;
    endsequence

    sequence s_quiet3;
        masterResetN [*3];
    endsequence

    a_mode_held:
    assert property (masterResetN && $past(masterResetN)
                     |-> $stable(fwftMode))
        else $error("timing mode changed outside master reset");

    a_std_no_data:
    assert property (!fwftMode && masterResetN && readEnN
                     |=> $stable(readDataOut))
        else $error("data moved without a read request");

    a_fall_through:
    assert property (s_first_word ##1 s_quiet3 |=> !outputReadyN)
        else $error("first word did not fall through in time");

    a_write_store:
    assert property (wrAccept |=> wPtr == $past(wPtr) + CNT_W'(1))
        else $error("accepted write did not advance pointer");

    a_empty_flag:
    assert property (!fwftMode && masterResetN && rdEmpty
                     |=> !emptyFlagN)
        else $error("empty flag not low with nothing stored");

    a_read_empty:
    assert property (masterResetN && rdEmpty |=> $stable(rPtr))
        else $error("read taken from empty buffer");

    a_full_block:
    assert property (masterResetN && wrFull && !writeEnN
                     |=> $stable(wPtr) && (fwftMode || !fullFlagN))
        else $error("write taken or flag high while full");

    a_full_release:
    assert property (s_full_read ##1 s_quiet3 |=> fullFlagN)
        else $error("full flag not released after a read");

    a_half_full:
    assert property (masterResetN && exCount >= hfLevel
                     |=> !halfFullFlagN)
        else $error("half-full flag missed its level");

    a_almost_full:
    assert property (masterResetN && afCount >= afLevel
                     |=> !almostFullFlagN)
        else $error("almost-full flag missed its level");

    a_almost_empty:
    assert property (masterResetN && aeCount <= emptyOfs
                     |=> !almostEmptyFlagN)
        else $error("almost-empty flag missed its level");

    a_gray_step:
    assert property (masterResetN && $past(masterResetN)
                     |-> $onehot0(wGray ^ $past(wGray)))
        else $error("write gray pointer moved more than one bit");
endmodule : dcf_fifo_top
`default_nettype wire

// ---- design/dcf_gray_sync.sv ----
/*
 * Two-stage synchroniser for a gray-coded pointer.
 * Assumes the source changes at most one bit per clock.
 */
`timescale 1ns/1ps
`default_nettype none
module dcf_gray_sync (
    // System
    input wire logic clk,
    input wire logic rstn,
    input wire logic clr,
    // Pointer in and out
    input wire logic [dcf_pkg::CNT_W-1:0] grayIn,
    output logic [dcf_pkg::CNT_W-1:0] grayOut
);
    import dcf_pkg::*;
    logic [CNT_W-1:0] stage1;

    // First stage is read only by the second
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stage1 <= '0;
            grayOut <= '0;
        end else if (clr) begin
            stage1 <= '0;
            grayOut <= '0;
        end else begin
            stage1 <= grayIn;
            grayOut <= stage1;
        end
    end
endmodule : dcf_gray_sync
`default_nettype wire

// ---- design/dcf_pkg.sv ----
/*
 * Shared constants for the dual-clock style FIFO with status flags:
 * depths, default offsets, register map and status field positions.
 * Assumes one system clock and an AHB-Lite register port.
 */
`default_nettype none
package dcf_pkg;
    // Variant and data path
    localparam bit VARIANT_LARGE = 1'b0;
    localparam int DATA_W = 18;
    localparam int NARROW_W = 9;
    localparam int ADDR_W = VARIANT_LARGE ? 19 : 18;
    localparam int CNT_W = ADDR_W + 1;
    // Depth with either port at 18 bits, and with both at 9 bits
    localparam logic [CNT_W-1:0] DEPTH_X18 =
        CNT_W'(VARIANT_LARGE ? 32'h0004_0000 : 32'h0002_0000);
    localparam logic [CNT_W-1:0] DEPTH_X9 =
        CNT_W'(VARIANT_LARGE ? 32'h0008_0000 : 32'h0004_0000);
    // Default offsets indexed by {load, select a, select b}
    localparam logic [15:0] OFS_DEF [8] = '{
        16'h007F, 16'h3FFF, 16'h1FFF, 16'h0FFF,
        16'h03FF, 16'h07FF, 16'h01FF, 16'h00FF};
    localparam int OFS_RESET_IDX = 0;
    // Register map, byte addresses within the slave window
    localparam logic [11:0] REG_EMPTY_OFS = 12'h000;
    localparam logic [11:0] REG_FULL_OFS = 12'h004;
    localparam logic [11:0] REG_STATUS = 12'h008;
    localparam logic [11:0] REG_CONFIG = 12'h00C;
    // Status register fields (pin levels as driven)
    localparam int STAT_EMPTY = 0;
    localparam int STAT_FULL = 1;
    localparam int STAT_AEMPTY = 2;
    localparam int STAT_AFULL = 3;
    localparam int STAT_HALF = 4;
    localparam int STAT_OREADY = 5;
    localparam int STAT_ISPACE = 6;
    localparam int STAT_COUNT = 8;
    // Config register fields, straps caught at master reset
    localparam int CFG_FALL_THROUGH_TIMING = 0;
    localparam int CFG_SYNCFLAG = 1;
    localparam int CFG_IN18 = 2;
    localparam int CFG_OUT18 = 3;
    localparam int CFG_LOAD = 4;
    // AHB transfer type bit that marks NONSEQ or SEQ
    localparam int HTRANS_ACTIVE = 1;
endpackage : dcf_pkg
`default_nettype wire

// ---- design/dcf_ram.sv ----
/*
 * Word storage with one write port and one registered read port.
 * Assumes the caller never reads a word that is not yet written.
 */
`timescale 1ns/1ps
`default_nettype none
module dcf_ram (
    // System
    input wire logic clk,
    input wire logic rstn,
    // Write side
    input wire logic wrEn,
    input wire logic [dcf_pkg::ADDR_W-1:0] wrAddr,
    input wire logic [dcf_pkg::DATA_W-1:0] wrData,
    // Read side
    input wire logic rdEn,
    input wire logic [dcf_pkg::ADDR_W-1:0] rdAddr,
    output logic [dcf_pkg::DATA_W-1:0] rdData
);
    import dcf_pkg::*;
    logic [DATA_W-1:0] mem [2**ADDR_W];

    // No reset on the array so it maps onto block memory
    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    // Output only moves on a read, so data holds between requests
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdData <= '0;
        end else if (rdEn) begin
            rdData <= mem[rdAddr];
        end
    end
endmodule : dcf_ram
`default_nettype wire

// ---- sim/dcf_fifo_top_test.sv ----
/*
 * Self-checking bench for the FIFO: offsets, modes, flags, data.
 * Assumes one clock and a zero-wait AHB-Lite slave.
 */
`timescale 1ns/1ps
`default_nettype none
module dcf_fifo_top_test;
    import dcf_pkg::*;
    localparam logic [15:0] OFS_EXP [8] = '{16'h007F, 16'h3FFF, 16'h1FFF,
        16'h0FFF, 16'h03FF, 16'h07FF, 16'h01FF, 16'h00FF};
    logic clk, rstn, masterResetN, modeSel, flagTiming, loadSel, selA, selB;
    logic in18, out18, writeEnN, readEnN, hsel, hwrite, hreadyout, hresp;
    logic start, slow, gotWord, busy, rdPhase;
    logic emptyFlagN, fullFlagN, almostEmptyFlagN, almostFullFlagN;
    logic halfFullFlagN, outputReadyN, inputSpaceN;
    logic [DATA_W-1:0] writeData, readDataOut;
    logic [31:0] haddr, hwdata, hrdata, rndState, lastWord, rdNote, regNote;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] count;
    int errCount, checked, cycles;
    logic [31:0] wordQ[$];
    logic [31:0] regQ[$];

    dcf_fifo_top dut_u (.clk(clk), .rstn(rstn), .masterResetN(masterResetN),
        .modeSelectSerialIn(modeSel), .flagTimingSelect(flagTiming),
        .offsetLoadSelect(loadSel), .defaultOffsetSelectA(selA),
        .defaultOffsetSelectB(selB), .inWidth18(in18), .outWidth18(out18),
        .writeEnN(writeEnN), .writeData(writeData), .readEnN(readEnN),
        .readDataOut(readDataOut), .emptyFlagN(emptyFlagN),
        .fullFlagN(fullFlagN), .almostEmptyFlagN(almostEmptyFlagN),
        .almostFullFlagN(almostFullFlagN), .halfFullFlagN(halfFullFlagN),
        .outputReadyN(outputReadyN), .inputSpaceN(inputSpaceN), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata));
    dcf_reader_model reader_u (.clk(clk), .rstn(rstn), .start(start),
        .slow(slow), .count(count), .readEnN(readEnN), .gotWord(gotWord),
        .busy(busy));

    // Free-running clock, 10 ns period
    always #5 clk = ~clk;

    function automatic logic [31:0] rnd();
        rndState = rndState ^ (rndState << 13);
        rndState = rndState ^ (rndState >> 17);
        rndState = rndState ^ (rndState << 5);
        return rndState;
    endfunction : rnd

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errCount++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic stop_test();
        if (errCount == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test

    // Address phase held until hready, then data phase until hready
    task automatic ahb_xfer(input logic wr, input logic [31:0] addr,
                            input logic [31:0] data);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= addr;
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= data;
        rdPhase <= !wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rdPhase <= 1'b0;
    endtask : ahb_xfer

    task automatic ahb_read(input logic [31:0] addr, input logic [31:0] exp);
        regQ.push_back(exp);
        ahb_xfer(1'b0, addr, 32'h0000_0000);
    endtask : ahb_read

    // Mode strap changes on release to show it was caught during reset
    task automatic mreset(input logic mode, input logic ft,
                          input logic [2:0] ofs);
        @(posedge clk);
        masterResetN <= 1'b0;
        modeSel <= mode;
        flagTiming <= ft;
        {loadSel, selA, selB} <= ofs;
        repeat (4) @(posedge clk);
        masterResetN <= 1'b1;
        modeSel <= !mode;
        repeat (3) @(posedge clk);
    endtask : mreset

    task automatic write_words(input int n, input bit keep);
        logic [31:0] d;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            d = rnd();
            writeEnN <= 1'b0;
            writeData <= d[DATA_W-1:0];
            lastWord = 32'(d[DATA_W-1:0]);
            if (keep) wordQ.push_back(lastWord);
        end
        @(posedge clk);
        writeEnN <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : write_words

    task automatic read_words(input logic [7:0] n, input logic sl);
        @(posedge clk);
        start <= 1'b1;
        count <= n;
        slow <= sl;
        @(posedge clk);
        start <= 1'b0;
        do @(posedge clk); while (busy);
        repeat (4) @(posedge clk);
    endtask : read_words

    // Results are compared against the oldest note as they appear
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (gotWord) begin
            rdNote = wordQ.pop_front();
            check("readDataOut", 32'(readDataOut), rdNote);
        end
        if (rdPhase && hreadyout) begin
            regNote = regQ.pop_front();
            check("hrdata", hrdata, regNote);
        end
        if (cycles == 20000) begin
            errCount++;
            stop_test();
        end
    end

    // Main sequence
    initial begin
        {clk, rstn, masterResetN, loadSel, selA, selB, out18} = '0;
        {modeSel, writeData, hsel, haddr, htrans, hwrite, hwdata} = '0;
        {start, slow, count, rdPhase, errCount, checked, cycles} = '0;
        {in18, flagTiming, writeEnN} = 3'b111;
        hsize = 3'b010;
        rndState = 32'h0000_60d7;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            mreset(1'b0, 1'b0, 3'(i));
            ahb_read(32'(REG_EMPTY_OFS), 32'(OFS_EXP[i]));
            ahb_read(32'(REG_FULL_OFS), 32'(OFS_EXP[i]));
        end
        mreset(1'b1, 1'b0, 3'b000);
        ahb_read(32'(REG_CONFIG), 32'h0000_0005);
        write_words(1, 1'b0);
        check("outputReadyN", 32'(outputReadyN), 32'h0000_0000);
        check("first word", 32'(readDataOut), lastWord);
        check("inputSpaceN", 32'(inputSpaceN), 32'h0000_0000);
        mreset(1'b0, 1'b1, 3'b000);
        ahb_read(32'(REG_CONFIG), 32'h0000_0006);
        ahb_read(32'(REG_STATUS), 32'h0000_007A);
        ahb_xfer(1'b1, 32'(REG_EMPTY_OFS), 32'h0000_0003);
        ahb_xfer(1'b1, 32'(REG_FULL_OFS),
                 32'(DEPTH_X18) - 32'h0000_0006);
        ahb_xfer(1'b1, 32'h0000_0010, 32'hFFFF_FFFF);
        ahb_read(32'h0000_0010, 32'h0000_0000);
        ahb_xfer(1'b1, 32'(REG_STATUS), 32'h0000_0000);
        ahb_read(32'(REG_EMPTY_OFS), 32'h0000_0003);
        write_words(3, 1'b1);
        check("emptyFlagN", 32'(emptyFlagN), 32'h0000_0001);
        check("almostEmptyFlagN", 32'(almostEmptyFlagN), 32'h0000_0000);
        write_words(1, 1'b1);
        check("almostEmptyFlagN", 32'(almostEmptyFlagN), 32'h0000_0001);
        write_words(1, 1'b1);
        check("almostFullFlagN", 32'(almostFullFlagN), 32'h0000_0001);
        write_words(1, 1'b1);
        check("almostFullFlagN", 32'(almostFullFlagN), 32'h0000_0000);
        write_words(2, 1'b1);
        check("fullFlagN", 32'(fullFlagN), 32'h0000_0001);
        check("halfFullFlagN", 32'(halfFullFlagN), 32'h0000_0001);
        ahb_read(32'(REG_STATUS), 32'h0000_0877);
        read_words(8'd5, 1'b0);
        check("almostEmptyFlagN", 32'(almostEmptyFlagN),
              32'h0000_0000);
        check("almostFullFlagN", 32'(almostFullFlagN), 32'h0000_0001);
        ahb_read(32'(REG_STATUS), 32'h0000_037B);
        wordQ.push_back(lastWord);
        read_words(8'd4, 1'b1);
        check("emptyFlagN", 32'(emptyFlagN), 32'h0000_0000);
        ahb_read(32'(REG_STATUS), 32'h0000_007A);
        repeat (3) @(posedge clk);
        check("words left", 32'(wordQ.size()), 32'h0000_0000);
        stop_test();
    end
endmodule : dcf_fifo_top_test
`default_nettype wire

// ---- sim/dcf_reader_model.sv ----
/*
 * Reader logic model that drives the FIFO read enable.
 * Assumes the FIFO clock and a bench that starts it only when idle.
 */
`timescale 1ns/1ps
`default_nettype none
module dcf_reader_model (
    // System
    input wire logic clk,
    input wire logic rstn,
    // Command from the bench
    input wire logic start,
    input wire logic slow,
    input wire logic [7:0] count,
    // Read port and status
    output logic readEnN,
    output logic gotWord,
    output logic busy
);
    logic [7:0] left;
    wire logic [7:0] nextLeft;
    // One request is used up at every edge where it stands
    assign nextLeft = start ? count : left - 8'(!readEnN);
    assign busy = (left != 8'h00) || !readEnN;
    // Slow mode leaves an idle cycle after each request
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            left <= 8'h00;
            readEnN <= 1'b1;
            gotWord <= 1'b0;
        end else begin
            left <= nextLeft;
            readEnN <= !(nextLeft != 8'h00 && (!slow || readEnN));
            gotWord <= !readEnN;
        end
    end
endmodule : dcf_reader_model
`default_nettype wire
